//--- pca_base_consts.vh
`ifndef PCA_BASE_CONSTS_VH
`define PCA_BASE_CONSTS_VH

// ----------------------------------------------------------------------
// register addresses on the special function bus
// ----------------------------------------------------------------------
`define ADDR_COUNT_LOW_RELOAD   8'hCE
`define ADDR_COUNT_HIGH_RELOAD  8'hCF
`define ADDR_ARRAY_CTRL         8'hD8
`define ADDR_ARRAY_MODE         8'hD9
`define ADDR_COUNT_LOW_BYTE     8'hE9
`define ADDR_PWM_AUX6           8'hF2
`define ADDR_PWM_AUX7           8'hF3
`define ADDR_COUNT_HIGH_BYTE    8'hF9

// ----------------------------------------------------------------------
// register pages
// ----------------------------------------------------------------------
`define PAGE_CTRL               4'h0
`define PAGE_PWM_AUX_HI         4'h1

// ----------------------------------------------------------------------
// field positions in the mode register
// ----------------------------------------------------------------------
`define MODE_IDLE_GATE          7
`define MODE_PAIR45_BUF         6
`define MODE_PAIR23_BUF         5
`define MODE_PAIR01_BUF         4
`define MODE_SRC_HI             3
`define MODE_SRC_LO             1
`define MODE_OVF_IRQ_EN         0

// ----------------------------------------------------------------------
// field positions in the control register and aux register
// ----------------------------------------------------------------------
`define CTRL_OVF_FLAG           7
`define CTRL_RUN                6
`define AUX_EVENT_FLAG          3

// ----------------------------------------------------------------------
// count source encodings
// ----------------------------------------------------------------------
`define SRC_DIV12               3'h0
`define SRC_DIV2                3'h1
`define SRC_TIMER0              3'h2
`define SRC_EXTERNAL            3'h3
`define SRC_MIXED               3'h4
`define SRC_SYSTEM_CLOCK_SOURCE              3'h5
`define SRC_BAUD                3'h6
`define SRC_MCK_DIV             3'h7

// ----------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------
`define RST_BYTE                8'h00
`define COUNT_ALL_ONES          16'hFFFF
`define DIV12_LAST              4'hB
`define UNMAPPED_READ           8'h00

`endif

//--- pca_base_timer_counter.v
// Behaviour
// - 16-bit counter reloads both bytes on overflow
// - three-bit select picks the count source
// - external source counts falling pin edges
// - idle gate bit stops counting in idle
// - pair buffer enables need capture/pwm/compare_on_pwm_match mode
// - overflow enable gates overflow interrupt request
// - overflow toggles clock-out, pin when enabled
// - run bit starts and stops the counter
// - overflow flag sticky, software may set it
// - module 0-5 flags set by hardware or by a software write
// - module 6-7 flags live in aux bit 3
// - modules 6-7 have no capture mode
// - unused module pins stay general-purpose I/O
// - count and reload bytes readable in all pages
// - module flag interrupts gated by module enable
`timescale 1ns/10ps
`include "pca_base_consts.vh"

module pca_base_timer_counter #(
	parameter MODULES = 8	// number of compare modules sharing the base
) (
	input  wire                 ref_clk_in,          // system clock
	input  wire                 sys_rst_in,          // synchronous reset, high
	input  wire [7:0]           sfr_addr_in,         // register address
	input  wire [3:0]           sfr_page_in,         // current register page
	input  wire                 sfr_wr_in,           // write strobe
	input  wire [7:0]           sfr_wdata_in,        // write data
	input  wire                 idle_mode_in,        // processor in idle
	input  wire                 timer0_overflow_in,  // timer0 overflow pulse
	input  wire                 external_count_input_in,          // count pin
	input  wire                 mixed_high_speed_clock_in,        // mixed clock tick
	input  wire                 serial_baud_generator_overflow_in, // baud tick
	input  wire                 master_clock_divider_out_in,      // divider tick
	input  wire                 clock_out_enable_in,  // clock-out pin enable
	input  wire                 clock_out_gpio_in,    // port value when not clock-out
	input  wire [MODULES-1:0]   match_event_in,       // module match strobes
	input  wire [MODULES-1:0]   capture_event_in,     // module capture strobes
	input  wire [MODULES-1:0]   module_irq_enable_in, // per-module irq enables
	input  wire [2:0]           pair_mode_ok_in,      // pair in capture/pwm/compare_on_pwm_match
	input  wire [MODULES-1:0]   module_pin_use_in,    // module owns its pin
	input  wire [MODULES-1:0]   module_pin_value_in,  // module's pin value
	input  wire [MODULES-1:0]   gpio_value_in,        // port latch value
	output reg  [7:0]           sfr_rdata_out,        // read data, one cycle late
	output reg  [15:0]          count_value_out,      // shared time base
	output reg                  overflow_out,         // one-cycle rollover pulse
	output reg                  irq_out,              // merged interrupt request
	output reg  [2:0]           buffer_enable_out,    // effective pair buffer modes
	output reg                  clock_out_pin_out,    // clock-out port pin
	output reg  [MODULES-1:0]   module_pin_out        // module port pins
);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------

	// true when an address lands on a register in the current page
	function hit;
		input [7:0] addr;
		input [3:0] page;
		input [7:0] target;
		input       all_pages;
		input [3:0] want_page;
		begin
			hit = (addr == target) && (all_pages || (page == want_page));
		end
	endfunction

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	reg  [7:0]         low_reload_reg;     // count_low_reload
	reg  [7:0]         high_reload_reg;    // count_high_reload
	reg  [7:0]         mode_reg;           // array_counter_mode
	reg                ovf_flag_reg;       // overflow_flag
	reg                run_reg;            // run_control_bit
	reg  [5:0]         event_flag_reg;     // module_event_flag 0..5
	reg  [7:0]         aux6_reg;           // pwm_auxiliary module 6
	reg  [7:0]         aux7_reg;           // pwm_auxiliary module 7
	reg  [3:0]         div12_reg;          // divide-by-12 prescaler
	reg                div2_reg;           // divide-by-2 prescaler
	reg                ext_pin_reg;        // previous external pin level
	reg                toggle_reg;         // overflow_toggle_out

	// ------------------------------------------------------------------
	// decoded strobes and next values
	// ------------------------------------------------------------------
	wire               wr_low_reload;      // write count_low_reload
	wire               wr_high_reload;     // write count_high_reload
	wire               wr_ctrl;            // write control register
	wire               wr_mode;            // write mode register
	wire               wr_count_low;       // write count low byte
	wire               wr_count_high;      // write count high byte
	wire               wr_aux6;            // write aux module 6
	wire               wr_aux7;            // write aux module 7
	wire [2:0]         source_sel;         // count_source_select
	wire               idle_gate_bit;      // idle gating enable
	wire               overflow_irq_enable; // overflow interrupt enable
	wire [2:0]         pair_buffer_bits;   // pair45, pair23, pair01
	reg                src_tick;           // selected source pulse
	wire               count_tick;         // counter advances this cycle
	wire               rollover;           // count passes all ones
	reg  [15:0]        count_next;         // next count value
	wire [5:0]         low_flag_set;       // hardware set, modules 0..5
	wire [1:0]         high_flag_set;      // hardware set, modules 6..7
	wire [MODULES-1:0] flags_all;          // all module flags
	wire [MODULES-1:0] pin_next;           // next port pin values
	reg  [7:0]         rdata_next;         // read mux

	// register writes; the count and reload bytes answer in every page
	assign wr_low_reload  = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_COUNT_LOW_RELOAD, 1'b1, `PAGE_CTRL);
	assign wr_high_reload = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_COUNT_HIGH_RELOAD, 1'b1, `PAGE_CTRL);
	assign wr_count_low   = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_COUNT_LOW_BYTE, 1'b1, `PAGE_CTRL);
	assign wr_count_high  = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_COUNT_HIGH_BYTE, 1'b1, `PAGE_CTRL);
	assign wr_ctrl        = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_ARRAY_CTRL, 1'b0, `PAGE_CTRL);
	assign wr_mode        = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_ARRAY_MODE, 1'b0, `PAGE_CTRL);
	assign wr_aux6        = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_PWM_AUX6, 1'b0, `PAGE_PWM_AUX_HI);
	assign wr_aux7        = sfr_wr_in && hit(sfr_addr_in, sfr_page_in,
		`ADDR_PWM_AUX7, 1'b0, `PAGE_PWM_AUX_HI);

	// mode register fields
	assign source_sel          = mode_reg[`MODE_SRC_HI:`MODE_SRC_LO];
	assign idle_gate_bit       = mode_reg[`MODE_IDLE_GATE];
	assign overflow_irq_enable = mode_reg[`MODE_OVF_IRQ_EN];
	assign pair_buffer_bits    = {mode_reg[`MODE_PAIR45_BUF],
		mode_reg[`MODE_PAIR23_BUF], mode_reg[`MODE_PAIR01_BUF]};

	// ------------------------------------------------------------------
	// count source selection
	// ------------------------------------------------------------------

	// one pulse per source event; fast sources arrive as ticks and
	// must respect the clock ratio limits set by software
	always @*
	begin
		src_tick = 1'b0;
		case (source_sel)
			`SRC_DIV12:    src_tick = (div12_reg == `DIV12_LAST);
			`SRC_DIV2:     src_tick = div2_reg;
			`SRC_TIMER0:   src_tick = timer0_overflow_in;
			`SRC_EXTERNAL: src_tick = ext_pin_reg && !external_count_input_in;
			`SRC_MIXED:    src_tick = mixed_high_speed_clock_in;
			`SRC_SYSTEM_CLOCK_SOURCE:   src_tick = 1'b1;
			`SRC_BAUD:     src_tick = serial_baud_generator_overflow_in;
			`SRC_MCK_DIV:  src_tick = master_clock_divider_out_in;
			default:       src_tick = 1'b0;
		endcase
	end

	// counting needs the run bit and, in idle with gating set, stops
	assign count_tick = src_tick && run_reg
		&& !(idle_gate_bit && idle_mode_in);

	// rollover is the count event taken from all ones
	assign rollover = count_tick && (count_value_out == `COUNT_ALL_ONES);

	// ------------------------------------------------------------------
	// next count value
	// ------------------------------------------------------------------

	// increment, reload on rollover, then let software writes win per byte
	always @*
	begin
		count_next = count_value_out;
		if (rollover)
		begin
			count_next = {high_reload_reg, low_reload_reg};
		end
		else if (count_tick)
		begin
			count_next = count_value_out + 16'h0001;
		end
		if (wr_count_low)
		begin
			count_next[7:0] = sfr_wdata_in;
		end
		if (wr_count_high)
		begin
			count_next[15:8] = sfr_wdata_in;
		end
	end

	// ------------------------------------------------------------------
	// module flag sources
	// ------------------------------------------------------------------

	// modules 0..5 flag on match or capture, 6..7 on match only
	assign low_flag_set  = match_event_in[5:0] | capture_event_in[5:0];
	assign high_flag_set = match_event_in[7:6];
	assign flags_all     = {aux7_reg[`AUX_EVENT_FLAG],
		aux6_reg[`AUX_EVENT_FLAG], event_flag_reg};

	// ------------------------------------------------------------------
	// pin sharing
	// ------------------------------------------------------------------

	// each pin follows its module while used, else ordinary port data
	genvar gi;
	generate
		for (gi = 0; gi < MODULES; gi = gi + 1)
		begin : g_pin
			assign pin_next[gi] = module_pin_use_in[gi] ?
				module_pin_value_in[gi] : gpio_value_in[gi];
		end
	endgenerate

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------

	// unmapped or off-page addresses read as zero
	always @*
	begin
		rdata_next = `UNMAPPED_READ;
		if (hit(sfr_addr_in, sfr_page_in, `ADDR_COUNT_LOW_RELOAD, 1'b1, `PAGE_CTRL))
		begin
			rdata_next = low_reload_reg;
		end
		else if (hit(sfr_addr_in, sfr_page_in, `ADDR_COUNT_HIGH_RELOAD, 1'b1, `PAGE_CTRL))
		begin
			rdata_next = high_reload_reg;
		end
		else if (hit(sfr_addr_in, sfr_page_in, `ADDR_COUNT_LOW_BYTE, 1'b1, `PAGE_CTRL))
		begin
			rdata_next = count_value_out[7:0];
		end
		else if (hit(sfr_addr_in, sfr_page_in, `ADDR_COUNT_HIGH_BYTE, 1'b1, `PAGE_CTRL))
		begin
			rdata_next = count_value_out[15:8];
		end
		else if (hit(sfr_addr_in, sfr_page_in, `ADDR_ARRAY_CTRL, 1'b0, `PAGE_CTRL))
		begin
			rdata_next = {ovf_flag_reg, run_reg, event_flag_reg};
		end
		else if (hit(sfr_addr_in, sfr_page_in, `ADDR_ARRAY_MODE, 1'b0, `PAGE_CTRL))
		begin
			rdata_next = mode_reg;
		end
		else if (hit(sfr_addr_in, sfr_page_in, `ADDR_PWM_AUX6, 1'b0, `PAGE_PWM_AUX_HI))
		begin
			rdata_next = aux6_reg;
		end
		else if (hit(sfr_addr_in, sfr_page_in, `ADDR_PWM_AUX7, 1'b0, `PAGE_PWM_AUX_HI))
		begin
			rdata_next = aux7_reg;
		end
	end

	// ------------------------------------------------------------------
	// prescalers and pin edge detect
	// ------------------------------------------------------------------

	// free-running dividers of the system clock
	always @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			div12_reg   <= 4'h0;
			div2_reg    <= 1'b0;
			ext_pin_reg <= 1'b0;
		end
		else
		begin
			div12_reg   <= (div12_reg == `DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
			div2_reg    <= !div2_reg;
			ext_pin_reg <= external_count_input_in;
		end
	end

	// ------------------------------------------------------------------
	// software registers and sticky flags
	// ------------------------------------------------------------------

	// hardware sets win over a software clear in the same cycle
	always @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			low_reload_reg  <= `RST_BYTE;
			high_reload_reg <= `RST_BYTE;
			mode_reg        <= `RST_BYTE;
			ovf_flag_reg    <= 1'b0;
			run_reg         <= 1'b0;
			event_flag_reg  <= 6'h00;
			aux6_reg        <= `RST_BYTE;
			aux7_reg        <= `RST_BYTE;
		end
		else
		begin
			if (wr_low_reload)
			begin
				low_reload_reg <= sfr_wdata_in;
			end
			if (wr_high_reload)
			begin
				high_reload_reg <= sfr_wdata_in;
			end
			if (wr_mode)
			begin
				mode_reg <= sfr_wdata_in;
			end
			// control register: software write, then hardware sets
			if (wr_ctrl)
			begin
				run_reg        <= sfr_wdata_in[`CTRL_RUN];
				ovf_flag_reg   <= sfr_wdata_in[`CTRL_OVF_FLAG] | rollover;
				event_flag_reg <= sfr_wdata_in[5:0] | low_flag_set;
			end
			else
			begin
				ovf_flag_reg   <= ovf_flag_reg | rollover;
				event_flag_reg <= event_flag_reg | low_flag_set;
			end
			// aux registers of modules 6 and 7, flag in bit 3
			if (wr_aux6)
			begin
				aux6_reg <= sfr_wdata_in;
				aux6_reg[`AUX_EVENT_FLAG] <= sfr_wdata_in[`AUX_EVENT_FLAG]
					| high_flag_set[0];
			end
			else
			begin
				aux6_reg[`AUX_EVENT_FLAG] <= aux6_reg[`AUX_EVENT_FLAG]
					| high_flag_set[0];
			end
			if (wr_aux7)
			begin
				aux7_reg <= sfr_wdata_in;
				aux7_reg[`AUX_EVENT_FLAG] <= sfr_wdata_in[`AUX_EVENT_FLAG]
					| high_flag_set[1];
			end
			else
			begin
				aux7_reg[`AUX_EVENT_FLAG] <= aux7_reg[`AUX_EVENT_FLAG]
					| high_flag_set[1];
			end
		end
	end

	// ------------------------------------------------------------------
	// counter, toggle and outputs
	// ------------------------------------------------------------------

	// all outputs are flops; irq sees the flag state of this cycle
	always @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			count_value_out   <= 16'h0000;
			toggle_reg        <= 1'b0;
			overflow_out      <= 1'b0;
			irq_out           <= 1'b0;
			buffer_enable_out <= 3'h0;
			clock_out_pin_out <= 1'b0;
			module_pin_out    <= {MODULES{1'b0}};
			sfr_rdata_out     <= `RST_BYTE;
		end
		else
		begin
			count_value_out   <= count_next;
			toggle_reg        <= toggle_reg ^ rollover;
			overflow_out      <= rollover;
			// merged request from enabled overflow and module flags
			irq_out           <= (ovf_flag_reg && overflow_irq_enable)
				|| (|(flags_all & module_irq_enable_in));
			buffer_enable_out <= pair_buffer_bits & pair_mode_ok_in;
			// clock-out on the pin only while enabled
			clock_out_pin_out <= clock_out_enable_in ?
				toggle_reg : clock_out_gpio_in;
			module_pin_out    <= pin_next;
			sfr_rdata_out     <= rdata_next;
		end
	end

endmodule // pca_base_timer_counter

//--- pca_base_monitor.sv
`timescale 1ns/10ps
module pca_base_monitor #(
	parameter MODULES = 8	// modules sharing the time base
) (
	input logic			ref_clk_in,
	input logic			sys_rst_in,
	input logic [7:0]		sfr_addr_in,
	input logic [3:0]		sfr_page_in,
	input logic			sfr_wr_in,
	input logic			clock_out_enable_in,
	input logic			clock_out_gpio_in,
	input logic [2:0]		pair_mode_ok_in,
	input logic [MODULES-1:0]	module_pin_use_in,
	input logic [MODULES-1:0]	module_pin_value_in,
	input logic [MODULES-1:0]	gpio_value_in,
	input logic [7:0]		sfr_rdata_out,
	input logic [15:0]		count_value_out,
	input logic			overflow_out,
	input logic			irq_out,
	input logic [2:0]		buffer_enable_out,
	input logic			clock_out_pin_out,
	input logic [MODULES-1:0]	module_pin_out
);
	// ----------------------------------------------------------------
	// address decode helpers
	// ----------------------------------------------------------------
	wire [7:0] count_high = count_value_out[15:8];	// high count byte
	wire any_page = (sfr_addr_in == 8'hCE) || (sfr_addr_in == 8'hCF) ||
		(sfr_addr_in == 8'hE9) || (sfr_addr_in == 8'hF9);	// count and reload bytes
	wire map_hit = any_page || ((sfr_page_in == 4'h0) && (sfr_addr_in[7:1] == 7'h6C)) ||
		((sfr_page_in == 4'h1) && (sfr_addr_in[7:1] == 7'h79));	// any mapped place
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_reset_quiet: assert property ($fell(sys_rst_in) |-> (count_value_out == 16'h0000) &&
		!irq_out && !overflow_out && (buffer_enable_out == 3'h0))
		else $error("outputs not idle after reset");
	a_count_step: assert property ((!$past(sfr_wr_in) && !$past(sys_rst_in) &&
		(count_value_out != $past(count_value_out))) |->
		((count_value_out == $past(count_value_out) + 16'h0001) || ($past(count_value_out) == 16'hFFFF)))
		else $error("count moved other than by one or rollover");
	a_ovf_from_ones: assert property (overflow_out |-> ($past(count_value_out) == 16'hFFFF))
		else $error("overflow pulse without all-ones count");
	a_clkout_toggle: assert property ((overflow_out && clock_out_enable_in &&
		$past(clock_out_enable_in)) |=> (clock_out_pin_out != $past(clock_out_pin_out)))
		else $error("clock-out pin did not toggle on overflow");
	a_clkout_gpio: assert property ((!$past(sys_rst_in) && !$past(clock_out_enable_in)) |->
		(clock_out_pin_out == $past(clock_out_gpio_in)))
		else $error("clock-out pin not port value while disabled");
	a_buffer_gate: assert property (!$past(sys_rst_in) |->
		((buffer_enable_out & ~$past(pair_mode_ok_in)) == 3'h0))
		else $error("buffer mode on for a pair in another mode");
	a_pin_share: assert property (!$past(sys_rst_in) |-> (module_pin_out ==
		(($past(module_pin_use_in) & $past(module_pin_value_in)) |
		(~$past(module_pin_use_in) & $past(gpio_value_in)))))
		else $error("module pin sharing wrong");
	a_unmapped_zero: assert property ((!$past(sys_rst_in) && !$past(map_hit)) |->
		(sfr_rdata_out == 8'h00))
		else $error("unmapped read not zero");
	a_count_read: assert property ((!$past(sys_rst_in) && ($past(sfr_addr_in) == 8'hF9) &&
		$stable(count_value_out)) |-> (sfr_rdata_out == $past(count_high)))
		else $error("high count byte read wrong");
endmodule // pca_base_monitor

bind pca_base_timer_counter pca_base_monitor #(.MODULES(MODULES)) u_monitor (
	.ref_clk_in, .sys_rst_in, .sfr_addr_in, .sfr_page_in, .sfr_wr_in, .clock_out_enable_in,
	.clock_out_gpio_in, .pair_mode_ok_in, .module_pin_use_in, .module_pin_value_in,
	.gpio_value_in, .sfr_rdata_out, .count_value_out, .overflow_out, .irq_out,
	.buffer_enable_out, .clock_out_pin_out, .module_pin_out
);

//--- test_pca_base_timer_counter.sv
`timescale 1ns/10ps
module test_pca_base_timer_counter;
	// ----------------------------------------------------------------
	// stimulus, all valued at time zero
	// ----------------------------------------------------------------
	reg		ref_clk_in = 1'b0;	// 100 MHz
	reg		sys_rst_in = 1'b1;	// held 20 cycles
	reg [7:0]	sfr_addr_in = 8'h00;	// register address
	reg [3:0]	sfr_page_in = 4'h0;	// register page
	reg		sfr_wr_in = 1'b0;	// write strobe
	reg [7:0]	sfr_wdata_in = 8'h00;	// write data
	reg		idle_mode_in = 1'b0;	// processor idle
	reg		clock_out_enable_in = 1'b1;	// clock-out onto pin
	reg		clock_out_gpio_in = 1'b0;	// pin value otherwise
	reg [7:0]	match_event_in = 8'h00;	// match strobes
	reg [7:0]	capture_event_in = 8'h00;	// capture strobes
	reg [7:0]	module_irq_enable_in = 8'h00;	// module irq enables
	reg [2:0]	pair_mode_ok_in = 3'h0;	// pairs in buffered modes
	reg [7:0]	module_pin_use_in = 8'h00;	// module owns pin
	reg [7:0]	module_pin_value_in = 8'h00;	// module pin values
	reg [7:0]	gpio_value_in = 8'h00;	// port latch values
	reg		auto_en = 1'b0;	// free-running tick sources on
	reg		t0_man = 1'b0;	// hand-made timer0 tick
	reg [1:0]	ph3 = 2'h0;	// modulo-3 phase
	reg [2:0]	ph8 = 3'h0;	// modulo-8 phase
	// tick rates differ so a wrong source shows a wrong count
	wire timer0_overflow_in = t0_man | (auto_en & (ph3 != 2'h0));
	wire external_count_input_in = auto_en & ph8[2];
	wire mixed_high_speed_clock_in = auto_en & (ph3 == 2'h0);
	wire serial_baud_generator_overflow_in = auto_en & (ph8[1:0] == 2'h0);
	wire master_clock_divider_out_in = auto_en & (ph8[1:0] != 2'h0);
	wire [7:0]	sfr_rdata_out;	// read data
	wire [15:0]	count_value_out;	// time base
	wire		overflow_out;	// rollover pulse
	wire		irq_out;	// merged request
	wire [2:0]	buffer_enable_out;	// pair buffer modes
	wire		clock_out_pin_out;	// clock-out pin
	wire [7:0]	module_pin_out;	// module pins
	integer	n_fail = 0;	// mismatches
	integer	samples_checked = 0;	// comparisons
	integer	ovf_seen = 0;	// overflow pulses seen
	integer	i;	// row index
	// rows: mode byte, idle level, ticks expected in a 24-cycle run
	localparam logic [24:0] ROWS [10] = '{{8'h00, 1'b0, 16'd2}, {8'h02, 1'b0, 16'd12},
		{8'h04, 1'b0, 16'd16}, {8'h06, 1'b0, 16'd3}, {8'h08, 1'b0, 16'd8},
		{8'h0A, 1'b0, 16'd24}, {8'h0C, 1'b0, 16'd6}, {8'h0E, 1'b0, 16'd18},
		{8'h8A, 1'b1, 16'd0}, {8'h0A, 1'b1, 16'd24}};

	pca_base_timer_counter #(.MODULES(8)) dut (
		.ref_clk_in, .sys_rst_in, .sfr_addr_in, .sfr_page_in, .sfr_wr_in, .sfr_wdata_in,
		.idle_mode_in, .timer0_overflow_in, .external_count_input_in,
		.mixed_high_speed_clock_in, .serial_baud_generator_overflow_in,
		.master_clock_divider_out_in, .clock_out_enable_in, .clock_out_gpio_in,
		.match_event_in, .capture_event_in, .module_irq_enable_in, .pair_mode_ok_in,
		.module_pin_use_in, .module_pin_value_in, .gpio_value_in, .sfr_rdata_out,
		.count_value_out, .overflow_out, .irq_out, .buffer_enable_out,
		.clock_out_pin_out, .module_pin_out);

	// ----------------------------------------------------------------
	// clock, tick phases, overflow counting
	// ----------------------------------------------------------------
	always #5 ref_clk_in = ~ref_clk_in;
	always @(negedge ref_clk_in)
	begin
		ph3 <= (ph3 == 2'h2) ? 2'h0 : ph3 + 2'h1;
		ph8 <= ph8 + 3'h1;
	end
	always @(posedge ref_clk_in)
		if (overflow_out === 1'b1)
			ovf_seen = ovf_seen + 1;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one-cycle write strobe, taken at the rising edge in between
	task wr_reg(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
		@(negedge ref_clk_in);
		sfr_addr_in = a;
		sfr_page_in = p;
		sfr_wdata_in = d;
		sfr_wr_in = 1'b1;
		@(negedge ref_clk_in);
		sfr_wr_in = 1'b0;
	endtask
	// read data lands one edge after the address
	task rd_reg(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e, input string n);
		@(negedge ref_clk_in);
		sfr_addr_in = a;
		sfr_page_in = p;
		@(posedge ref_clk_in);
		#1;
		chk(n, {8'h00, sfr_rdata_out}, {8'h00, e});
		@(negedge ref_clk_in);
	endtask
	task tick_t0;
		@(negedge ref_clk_in);
		t0_man = 1'b1;
		@(negedge ref_clk_in);
		t0_man = 1'b0;
		repeat (3) @(negedge ref_clk_in);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if ((n_fail == 0) && (samples_checked > 0))
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_fail = n_fail + 1;
		end_sim;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(negedge ref_clk_in);
		sys_rst_in = 1'b0;
		chk("count_reset", count_value_out, 16'h0000);
		rd_reg(8'hD9, 4'h0, 8'h00, "mode_reset");
		rd_reg(8'hCF, 4'h7, 8'h00, "reload_reset");
		auto_en = 1'b1;
		for (i = 0; i < 10; i = i + 1)
		begin
			idle_mode_in = ROWS[i][16];
			wr_reg(8'hD9, 4'h0, ROWS[i][24:17]);
			wr_reg(8'hE9, 4'h3, 8'h00);
			wr_reg(8'hF9, 4'h3, 8'h00);
			wr_reg(8'hD8, 4'h0, 8'h40);
			repeat (22) @(negedge ref_clk_in);
			wr_reg(8'hD8, 4'h0, 8'h00);
			rd_reg(8'hE9, 4'hF, ROWS[i][7:0], "count_low");
		end
		auto_en = 1'b0;
		idle_mode_in = 1'b0;
		wr_reg(8'hCE, 4'h5, 8'h34);
		wr_reg(8'hCF, 4'h9, 8'h12);
		wr_reg(8'hD9, 4'h0, 8'h05);
		wr_reg(8'hE9, 4'h0, 8'hFF);
		wr_reg(8'hF9, 4'h0, 8'hFF);
		wr_reg(8'hD8, 4'h0, 8'h40);
		ovf_seen = 0;
		tick_t0;
		chk("reload", count_value_out, 16'h1234);
		chk("ovf_pulses", ovf_seen[15:0], 16'h0001);
		chk("irq_ovf", {15'h0000, irq_out}, 16'h0001);
		chk("clk_toggle", {15'h0000, clock_out_pin_out}, 16'h0001);
		rd_reg(8'hD8, 4'h0, 8'hC0, "ctrl_ovf");
		rd_reg(8'hF9, 4'hB, 8'h12, "count_high");
		wr_reg(8'hD9, 4'h0, 8'h04);
		clock_out_enable_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		chk("irq_masked", {15'h0000, irq_out}, 16'h0000);
		chk("clk_gpio", {15'h0000, clock_out_pin_out}, 16'h0000);
		wr_reg(8'hD8, 4'h0, 8'h00);
		tick_t0;
		chk("stopped", count_value_out, 16'h1234);
		rd_reg(8'hD8, 4'h0, 8'h00, "ctrl_clear");
		wr_reg(8'hD8, 4'h0, 8'h80);
		rd_reg(8'hD8, 4'h0, 8'h80, "ctrl_soft_set");
		wr_reg(8'hD8, 4'h0, 8'h00);
		rd_reg(8'h10, 4'h0, 8'h00, "unmapped");
		// module events: capture on module 6 must be ignored
		@(negedge ref_clk_in);
		match_event_in = 8'h84;
		capture_event_in = 8'h60;
		@(negedge ref_clk_in);
		match_event_in = 8'h00;
		capture_event_in = 8'h00;
		rd_reg(8'hF3, 4'h1, 8'h08, "aux7_flag");
		rd_reg(8'hF2, 4'h1, 8'h00, "aux6_flag");
		chk("irq_gated", {15'h0000, irq_out}, 16'h0000);
		module_irq_enable_in = 8'h80;
		repeat (3) @(negedge ref_clk_in);
		chk("irq_module", {15'h0000, irq_out}, 16'h0001);
		wr_reg(8'hF3, 4'h1, 8'h00);
		repeat (2) @(negedge ref_clk_in);
		chk("irq_cleared", {15'h0000, irq_out}, 16'h0000);
		rd_reg(8'hD8, 4'h0, 8'h24, "ctrl_flags");
		pair_mode_ok_in = 3'h3;
		module_pin_use_in = 8'h0F;
		module_pin_value_in = 8'hAA;
		gpio_value_in = 8'h55;
		wr_reg(8'hD9, 4'h0, 8'h50);
		repeat (2) @(negedge ref_clk_in);
		chk("buffer", {13'h0000, buffer_enable_out}, 16'h0001);
		chk("pins", {8'h00, module_pin_out}, 16'h005A);
		// second reset in mid-run clears count and mode
		sys_rst_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		sys_rst_in = 1'b0;
		chk("count_rst2", count_value_out, 16'h0000);
		rd_reg(8'hD9, 4'h0, 8'h00, "mode_rst2");
		end_sim;
	end
endmodule // test_pca_base_timer_counter
